// *** dv/iofr_client.sv ***
module iofr_client
  import iofr_pkg::*;
#(
  parameter int NP = 2,
  parameter int CBW = 2,
  parameter int AW = 48
) (
  // Clock
  input wire logic clk,
  // Transaction outcome toward the recorder
  output logic [NP-1:0] in_valid,
  output iofr_kind_e [NP-1:0] in_kind,
  output logic [NP-1:0][CBW-1:0] in_cb,
  output logic [NP-1:0][CBW-1:0] in_s2cb,
  output logic [NP-1:0] in_nested,
  output logic [NP-1:0] in_s1walk,
  output logic [NP-1:0][AW-1:0] in_va,
  output logic [NP-1:0][AW-1:0] in_ipa,
  // Attributes and per-stream overrides
  output logic [NP-1:0] instruction_attr,
  output logic [NP-1:0] privileged_attr,
  output logic [NP-1:0] nonsecure_attribute,
  output logic [NP-1:0] in_secure,
  output logic [NP-1:0][1:0] instruction_override_cfg,
  output logic [NP-1:0][1:0] privilege_override_cfg,
  output logic [NP-1:0][1:0] secure_state_override_cfg
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {in_valid, in_cb, in_s2cb, in_nested, in_s1walk, in_va, in_ipa} = '0;
    {instruction_attr, privileged_attr, nonsecure_attribute, in_secure} = '0;
    instruction_override_cfg = '0;
    privilege_override_cfg = '0;
    secure_state_override_cfg = '0;
    foreach (in_kind[p]) in_kind[p] = K_NONE;
  end

  // The IPA is the inverse of the VA, so a wrong address pick shows.
  task automatic load(input int p, input iofr_kind_e k,
                      input logic [CBW-1:0] cb, input logic nest,
                      input logic walk, input logic [2:0] a,
                      input logic sec, input logic [5:0] ovr,
                      input logic [AW-1:0] va);
    in_kind[p] <= k;
    in_cb[p] <= cb;
    in_s2cb[p] <= cb;
    in_nested[p] <= nest;
    in_s1walk[p] <= walk;
    in_va[p] <= va;
    in_ipa[p] <= ~va;
    instruction_attr[p] <= a[2];
    privileged_attr[p] <= a[1];
    nonsecure_attribute[p] <= a[0];
    in_secure[p] <= sec;
    instruction_override_cfg[p] <= ovr[5:4];
    privilege_override_cfg[p] <= ovr[3:2];
    secure_state_override_cfg[p] <= ovr[1:0];
  endtask

  // Starting on a fresh edge keeps two fires from touching in_valid at once.
  task automatic fire(input logic [NP-1:0] mask);
    @(posedge clk);
    in_valid <= mask;
    @(posedge clk);
    in_valid <= '0;
  endtask
endmodule

// *** dv/iofr_fault_recording_tb.sv ***
module iofr_fault_recording_tb
  import iofr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NP = 2;
  localparam int NCB = 4;
  localparam int AW = 48;
  localparam int CBW = 2;
  localparam logic [AW-1:0] VA1 = 48'h0000_1111_2222;
  localparam logic [AW-1:0] VA2 = 48'h7777_8888_9999;
  typedef struct packed {
    iofr_kind_e k;
    logic [1:0] cb;
    logic nest;
    logic walk;
    logic [2:0] a;
    logic sec;
    logic [5:0] ovr;
    logic fre;
    logic [CS_W-1:0] cs;
    logic [GS_W-1:0] gs;
  } iofr_row_s;
  logic clk, resetn, gl_ack_en, gop_done, gop_fault, gop_ack;
  logic global_xlate_fault;
  logic [NP-1:0] in_valid, in_nested, in_s1walk, in_secure;
  logic [NP-1:0] instruction_attr, privileged_attr, nonsecure_attribute;
  logic [NP-1:0] resp_valid, resp_abort, resp_stall;
  iofr_kind_e [NP-1:0] in_kind;
  logic [NP-1:0][CBW-1:0] in_cb, in_s2cb;
  logic [NP-1:0][AW-1:0] in_va, in_ipa;
  logic [NP-1:0][1:0] instruction_override_cfg, privilege_override_cfg;
  logic [NP-1:0][1:0] secure_state_override_cfg;
  logic [NCB-1:0] fault_report_enable, hit_under_fault_ctrl;
  logic [NCB-1:0] stall_on_fault, stall_resume, ctx_ack_en;
  logic [NCB-1:0] op_done, op_s2_fault, xlate_op_terminated;
  logic [CS_MULTI:0] ctx_ack_data;
  logic [GS_MULTI:0] gl_ack_data;
  logic [NCB-1:0][CS_W-1:0] context_fault_status;
  logic [NCB-1:0][SYN_W-1:0] context_fault_syndrome;
  logic [NCB-1:0][AW-1:0] context_fault_address;
  logic [GS_W-1:0] global_fault_status;
  logic [SYN_W-1:0] global_fault_syndrome0;
  int errors = 0;
  int compares = 0;
  int n;
  logic ctx, glb;
  logic [AW-1:0] va;
  iofr_row_s r;
  iofr_row_s rows [10] = '{
    '{K_NONE, 2'h0, 1'h0, 1'h0, 3'h7, 1'h0, 6'h00, 1'h1, 5'h00, 5'h00},
    '{K_S1, 2'h1, 1'h0, 1'h0, 3'h2, 1'h1, 6'h3B, 1'h1, 5'h01, 5'h00},
    '{K_S2_TRANS, 2'h2, 1'h1, 1'h1, 3'h2, 1'h0, 6'h2B, 1'h1, 5'h01, 5'h00},
    '{K_S2_PERM, 2'h3, 1'h1, 1'h0, 3'h0, 1'h1, 6'h03, 1'h1, 5'h02, 5'h00},
    '{K_EXT, 2'h0, 1'h0, 1'h0, 3'h6, 1'h0, 6'h00, 1'h1, 5'h04, 5'h00},
    '{K_S2_TRANS, 2'h1, 1'h0, 1'h0, 3'h1, 1'h0, 6'h00, 1'h0, 5'h01, 5'h00},
    '{K_INV_CTX, 2'h2, 1'h1, 1'h0, 3'h4, 1'h1, 6'h3F, 1'h1, 5'h00, 5'h01},
    '{K_UNIMPL_CB, 2'h3, 1'h0, 1'h0, 3'h3, 1'h0, 6'h00, 1'h1, 5'h00, 5'h02},
    '{K_UNIMPL_IRPT, 2'h0, 1'h0, 1'h0, 3'h5, 1'h0, 6'h00, 1'h1, 5'h00, 5'h04},
    '{K_GLB_OTHER, 2'h1, 1'h0, 1'h0, 3'h2, 1'h0, 6'h00, 1'h1, 5'h00, 5'h08}
  };

  iofr_client #(.NP(NP), .CBW(CBW), .AW(AW)) i_iofr_client (
    .clk, .in_valid, .in_kind, .in_cb, .in_s2cb, .in_nested, .in_s1walk,
    .in_va, .in_ipa, .instruction_attr, .privileged_attr,
    .nonsecure_attribute, .in_secure, .instruction_override_cfg,
    .privilege_override_cfg, .secure_state_override_cfg);

  iofr_fault_recording #(.NP(NP), .NUM_CB(NCB), .AW(AW), .CBW(CBW))
    i_iofr_fault_recording (
    .clk, .resetn, .in_valid, .in_kind, .in_cb, .in_s2cb, .in_nested,
    .in_s1walk, .in_va, .in_ipa, .instruction_attr, .privileged_attr,
    .nonsecure_attribute, .in_secure, .instruction_override_cfg,
    .privilege_override_cfg, .secure_state_override_cfg,
    .fault_report_enable, .hit_under_fault_ctrl, .stall_on_fault,
    .stall_resume, .ctx_ack_en, .ctx_ack_data, .gl_ack_en, .gl_ack_data,
    .op_done, .op_s2_fault, .gop_done, .gop_fault, .gop_ack, .resp_valid,
    .resp_abort, .resp_stall, .context_fault_status,
    .context_fault_syndrome, .context_fault_address, .xlate_op_terminated,
    .global_fault_status, .global_fault_syndrome0, .global_xlate_fault);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [2:0] ovr_apply(logic [2:0] a, logic sec,
                                           logic [5:0] o);
    ovr_apply[2] = o[5] ? o[4] : a[2];
    ovr_apply[1] = o[3] ? o[2] : a[1];
    ovr_apply[0] = (o[1] && sec) ? o[0] : a[0];
  endfunction

  task automatic finish_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [AW-1:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic ack(input logic [NCB-1:0] m, input logic [CS_MULTI:0] d,
                     input logic g, input logic [GS_MULTI:0] gd);
    @(posedge clk);
    ctx_ack_en <= m;
    ctx_ack_data <= d;
    gl_ack_en <= g;
    gl_ack_data <= gd;
    @(posedge clk);
    ctx_ack_en <= '0;
    gl_ack_en <= 1'b0;
    #1;
  endtask

  task automatic go(input iofr_kind_e k, input logic [1:0] cb,
                    input logic nest, input logic [2:0] a,
                    input logic [AW-1:0] v);
    i_iofr_client.load(0, k, cb, nest, 1'b0, a, 1'b0, 6'h00, v);
    i_iofr_client.fire(2'h1);
    #1;
  endtask

  initial begin
    resetn = 1'b0;
    fault_report_enable = '1;
    hit_under_fault_ctrl = '1;
    {stall_on_fault, stall_resume, ctx_ack_en, op_done, op_s2_fault} = '0;
    {ctx_ack_data, gl_ack_data, gl_ack_en, gop_done, gop_fault} = '0;
    gop_ack = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk({context_fault_status, global_fault_status, resp_valid, resp_stall,
         xlate_op_terminated, global_xlate_fault}, '0, "reset");
    chk({context_fault_syndrome, global_fault_syndrome0, resp_abort}, '0,
        "reset syn");
    for (int i = 0; i < 10; i++) begin
      r = rows[i];
      va = {40'hA5A5123456, i[7:0]};
      ctx = |r.cs;
      glb = |r.gs;
      fault_report_enable <= {NCB{r.fre}};
      ack('1, 4'hF, 1'b1, 5'h1F);
      i_iofr_client.load(0, r.k, r.cb, r.nest, r.walk, r.a, r.sec, r.ovr, va);
      i_iofr_client.fire(2'h1);
      #1;
      chk({resp_valid, resp_abort[0]}, {2'h1, glb | (ctx & r.fre)},
          "resp");
      chk(context_fault_status[r.cb], r.cs, "cstat");
      chk(global_fault_status, r.gs, "gstat");
      if (ctx) begin
        chk(context_fault_syndrome[r.cb],
            {r.walk, ovr_apply(r.a, r.sec, r.ovr)}, "csyn");
        chk(context_fault_address[r.cb],
            (r.nest || r.k == K_S1) ? va : ~va, "addr");
      end
      if (glb) begin
        chk(global_fault_syndrome0[ATTR_W-1:0], r.a, "gsyn");
      end
      if (ctx && r.k != K_S1) begin
        chk(global_fault_syndrome0[GSYN_NESTED], r.nest, "nested");
      end
    end
    ack('1, 4'hF, 1'b1, 5'h1F);
    go(K_S2_PERM, 2'h1, 1'b1, 3'h5, VA1);
    go(K_EXT, 2'h1, 1'b0, 3'h2, VA2);
    chk(context_fault_status[1], 5'h0A, "multi");
    chk(context_fault_syndrome[1], 4'h5, "first syn");
    chk(context_fault_address[1], VA1, "first addr");
    ack(4'h2, 4'h0, 1'b0, 5'h00);
    chk(context_fault_status[1], 5'h0A, "ack zero");
    ack(4'h2, 4'h2, 1'b0, 5'h00);
    chk(context_fault_status[1], 5'h08, "ack pf");
    go(K_S2_TRANS, 2'h1, 1'b1, 3'h0, VA2);
    chk(context_fault_status[1], 5'h08, "pending");
    ack(4'h2, 4'h8, 1'b0, 5'h00);
    go(K_EXT, 2'h1, 1'b1, 3'h2, VA2);
    chk(context_fault_status[1], 5'h04, "new first");
    chk(context_fault_address[1], VA2, "new addr");
    go(K_INV_CTX, 2'h0, 1'b0, 3'h1, VA1);
    go(K_UNIMPL_CB, 2'h0, 1'b0, 3'h6, VA2);
    chk(global_fault_status, 5'h11, "gmulti");
    chk(global_fault_syndrome0[2:0], 3'h1, "gfirst");
    ack('1, 4'hF, 1'b1, 5'h1F);
    i_iofr_client.load(0, K_S2_TRANS, 2'h2, 1'b0, 1'b0, 3'h3, 1'b0, 6'h00,
                       VA1);
    i_iofr_client.load(1, K_EXT, 2'h2, 1'b0, 1'b0, 3'h4, 1'b0, 6'h00, VA2);
    i_iofr_client.fire(2'h3);
    #1;
    chk(resp_valid, 2'h3, "pair valid");
    chk(context_fault_status[2], 5'h09, "pair");
    chk(context_fault_syndrome[2], 4'h3, "pair syn");
    // Controls settle before any traffic reaches the bank.
    hit_under_fault_ctrl <= 4'h7;
    ack('1, 4'hF, 1'b1, 5'h1F);
    go(K_S2_TRANS, 2'h3, 1'b1, 3'h1, VA1);
    chk(resp_abort[0], 1'b1, "s2 abort");
    go(K_S2_PERM, 2'h3, 1'b1, 3'h6, VA2);
    chk(resp_abort[0], 1'b1, "blocked");
    chk(context_fault_status, 20'h08000, "silent");
    fault_report_enable <= 4'h7;
    go(K_NONE, 2'h3, 1'b1, 3'h0, VA2);
    chk({resp_valid[0], resp_abort[0]}, 2'h2, "no report");
    hit_under_fault_ctrl <= '1;
    fault_report_enable <= '1;
    stall_on_fault <= 4'h1;
    ack('1, 4'hF, 1'b1, 5'h1F);
    go(K_S2_PERM, 2'h0, 1'b1, 3'h0, VA1);
    repeat (3) @(posedge clk);
    #1;
    chk({resp_stall[0], resp_valid[0]}, 2'h2, "stalled");
    chk(context_fault_status[0][CS_SS], 1'b1, "ss");
    @(posedge clk);
    stall_resume <= 4'h1;
    @(posedge clk);
    stall_resume <= '0;
    for (n = 0; n < 4; n++) begin
      #1;
      if (resp_valid[0] === 1'b1) break;
      @(posedge clk);
    end
    if (n == 4) begin
      errors++;
      finish_test();
    end
    chk({resp_stall[0], resp_abort[0]}, 2'h0, "resume");
    stall_on_fault <= '0;
    // Bank 0 still holds its fault while its operation runs.
    @(posedge clk);
    {op_done, op_s2_fault, gop_done, gop_fault} <= {4'h3, 4'h1, 2'h3};
    @(posedge clk);
    {op_done, op_s2_fault, gop_done, gop_fault} <= '0;
    #1;
    chk(xlate_op_terminated, 4'h1, "ops");
    chk({global_xlate_fault, global_fault_status}, 6'h20, "gop");
    @(posedge clk);
    {gop_ack, op_done} <= {1'b1, 4'h1};
    @(posedge clk);
    {gop_ack, op_done} <= '0;
    #1;
    chk({xlate_op_terminated, global_xlate_fault}, '0, "op clr");
    finish_test();
  end
endmodule

// *** rtl/iofr_fault_recording.sv ***
module iofr_fault_recording
  import iofr_pkg::*;
#(
  parameter int NP = 2,
  parameter int NUM_CB = 4,
  parameter int AW = 48,
  parameter int CBW = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Translated client transaction outcome, one per port
  input wire logic [NP-1:0] in_valid,
  input wire iofr_kind_e [NP-1:0] in_kind,
  input wire logic [NP-1:0][CBW-1:0] in_cb,
  input wire logic [NP-1:0][CBW-1:0] in_s2cb,
  input wire logic [NP-1:0] in_nested,
  input wire logic [NP-1:0] in_s1walk,
  input wire logic [NP-1:0][AW-1:0] in_va,
  input wire logic [NP-1:0][AW-1:0] in_ipa,
  // Incoming attributes and per-stream overrides
  input wire logic [NP-1:0] instruction_attr,
  input wire logic [NP-1:0] privileged_attr,
  input wire logic [NP-1:0] nonsecure_attribute,
  input wire logic [NP-1:0] in_secure,
  input wire logic [NP-1:0][1:0] instruction_override_cfg,
  input wire logic [NP-1:0][1:0] privilege_override_cfg,
  input wire logic [NP-1:0][1:0] secure_state_override_cfg,
  // Per-bank control
  input wire logic [NUM_CB-1:0] fault_report_enable,
  input wire logic [NUM_CB-1:0] hit_under_fault_ctrl,
  input wire logic [NUM_CB-1:0] stall_on_fault,
  input wire logic [NUM_CB-1:0] stall_resume,
  // Acknowledge writes
  input wire logic [NUM_CB-1:0] ctx_ack_en,
  input wire logic [CS_MULTI:0] ctx_ack_data,
  input wire logic gl_ack_en,
  input wire logic [GS_MULTI:0] gl_ack_data,
  // Address translation operations
  input wire logic [NUM_CB-1:0] op_done,
  input wire logic [NUM_CB-1:0] op_s2_fault,
  input wire logic gop_done,
  input wire logic gop_fault,
  input wire logic gop_ack,
  // Client responses
  output logic [NP-1:0] resp_valid,
  output logic [NP-1:0] resp_abort,
  output logic [NP-1:0] resp_stall,
  // Context bank records
  output wire logic [NUM_CB-1:0][CS_W-1:0] context_fault_status,
  output wire logic [NUM_CB-1:0][SYN_W-1:0] context_fault_syndrome,
  output wire logic [NUM_CB-1:0][AW-1:0] context_fault_address,
  output logic [NUM_CB-1:0] xlate_op_terminated,
  // Global record
  output wire logic [GS_W-1:0] global_fault_status,
  output wire logic [SYN_W-1:0] global_fault_syndrome0,
  output logic global_xlate_fault
);

  localparam int CDW = SYN_W + AW;

  function automatic logic ovr(logic v, logic [1:0] c);
    ovr = (c == OVR_ZERO) ? 1'b0 : (c == OVR_ONE) ? 1'b1 : v;
  endfunction

  function automatic logic kind_s2(iofr_kind_e k);
    kind_s2 = (k == K_S2_TRANS) || (k == K_S2_PERM) || (k == K_EXT);
  endfunction

  function automatic logic kind_glb(iofr_kind_e k);
    kind_glb = (k == K_INV_CTX) || (k == K_UNIMPL_CB) ||
               (k == K_UNIMPL_IRPT) || (k == K_GLB_OTHER);
  endfunction

  function automatic int lowest(logic [NP-1:0] v);
    lowest = 0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest = i;
      end
    end
  endfunction

  function automatic logic many(logic [NP-1:0] v);
    many = |(v & (v - 1'b1));
  endfunction

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Per-port decode.
  logic [NP-1:0] blocked, is_s2, stall_now, rec_ctx, rec_glb;
  logic [NP-1:0] term_nested, abort_nxt, resume_mine;
  logic [NP-1:0][CDW-1:0] ctx_det;
  logic [NP-1:0][CTX_BITS-1:0] ctx_bits;
  logic [NP-1:0][GL_BITS-1:0] glb_bits;
  logic [NP-1:0][ATTR_W-1:0] raw_attr;
  logic [NP-1:0][CBW-1:0] stall_cb_r;
  logic [NUM_CB-1:0] s2_aborted_r;
  logic nested_r;

  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      logic eff_ind, eff_pnu, eff_ns;
      logic [AW-1:0] rec_addr;

      assign is_s2[p] = kind_s2(in_kind[p]);
      // A nested transaction on a stage 2 bank that already aborted, with
      // hit-under-fault clear, is ended without any translation or context record.
      assign blocked[p] = in_valid[p] & in_nested[p] &
                          s2_aborted_r[in_s2cb[p]] &
                          ~hit_under_fault_ctrl[in_s2cb[p]];
      assign stall_now[p] = in_valid[p] & is_s2[p] & ~blocked[p] &
                            stall_on_fault[in_cb[p]];
      // Stage 2 kinds land in the stage 2 bank named by in_cb only; the
      // stage 1 bank sees nothing, even for a walk fault.
      assign rec_ctx[p] = in_valid[p] & ~blocked[p] &
                          (is_s2[p] | (in_kind[p] == K_S1));
      assign rec_glb[p] = in_valid[p] & kind_glb(in_kind[p]);
      assign term_nested[p] = rec_ctx[p] & is_s2[p] & in_nested[p] &
                              ~stall_now[p];
      assign abort_nxt[p] = blocked[p] ? fault_report_enable[in_s2cb[p]] :
                            rec_glb[p] ? 1'b1 :
                            (rec_ctx[p] & ~stall_now[p]) ?
                            fault_report_enable[in_cb[p]] : 1'b0;

      // Extra attributes, if ever added, must be taken from these
      // post-override values too.
      assign eff_ind = ovr(instruction_attr[p],
                           instruction_override_cfg[p]);
      assign eff_pnu = ovr(privileged_attr[p], privilege_override_cfg[p]);
      assign eff_ns = in_secure[p] ?
                      ovr(nonsecure_attribute[p],
                          secure_state_override_cfg[p]) :
                      nonsecure_attribute[p];
      assign raw_attr[p] = {instruction_attr[p], privileged_attr[p],
                            nonsecure_attribute[p]};
      assign rec_addr = (in_nested[p] || in_kind[p] == K_S1) ?
                        in_va[p] : in_ipa[p];
      assign ctx_det[p] = {in_nested[p] & in_s1walk[p] & is_s2[p],
                           eff_ind, eff_pnu, eff_ns, rec_addr};
      assign ctx_bits[p] = {in_kind[p] == K_EXT, in_kind[p] == K_S2_PERM,
                            (in_kind[p] == K_S2_TRANS) ||
                            (in_kind[p] == K_S1)};
      assign glb_bits[p] = {in_kind[p] == K_GLB_OTHER,
                            in_kind[p] == K_UNIMPL_IRPT,
                            in_kind[p] == K_UNIMPL_CB,
                            in_kind[p] == K_INV_CTX};
      assign resume_mine[p] = resp_stall[p] & stall_resume[stall_cb_r[p]];

      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          resp_valid[p] <= RST_BIT;
          resp_abort[p] <= RST_BIT;
          resp_stall[p] <= RST_BIT;
          stall_cb_r[p] <= {CBW{RST_BIT}};
        end else begin
          resp_valid[p] <= (in_valid[p] & ~stall_now[p]) | resume_mine[p];
          resp_abort[p] <= in_valid[p] & abort_nxt[p];
          resp_stall[p] <= stall_now[p] | (resp_stall[p] & ~resume_mine[p]);
          if (stall_now[p]) begin
            stall_cb_r[p] <= in_cb[p];
          end
        end
      end

      a_block_silent: assert property (blocked[p] |-> !rec_ctx[p] ##1
        resp_abort[p] == $past(fault_report_enable[in_s2cb[p]]))
        else $error("blocked transaction recorded or wrong abort");
      a_abort_report: assert property (rec_ctx[p] && !stall_now[p] |=>
        resp_valid[p] &&
        resp_abort[p] == $past(fault_report_enable[in_cb[p]]))
        else $error("abort does not follow report enable");
      a_stall_hold: assert property (stall_now[p] |=> resp_stall[p] &&
        !resp_valid[p])
        else $error("stalled transaction not held");
    end
  endgenerate

  // Context banks.
  logic [NUM_CB-1:0][NP-1:0] bhit, bstall, bterm;
  logic [NUM_CB-1:0][CDW-1:0] cap_det;

  genvar b;
  generate
    for (b = 0; b < NUM_CB; b++) begin : g_bank
      logic pend;

      for (p = 0; p < NP; p++) begin : g_hit
        assign bhit[b][p] = rec_ctx[p] & (in_cb[p] == CBW'(b));
        assign bstall[b][p] = stall_now[p] & (in_cb[p] == CBW'(b));
        assign bterm[b][p] = term_nested[p] & (in_cb[p] == CBW'(b));
      end
      assign cap_det[b] = ctx_det[lowest(bhit[b])];
      assign pend = |context_fault_status[b][CS_MULTI:0];

      iofr_record #(
        .SW(CTX_BITS),
        .DW(CDW)
      ) u_rec (
        .clk(clk),
        .resetn(resetn),
        .cap_valid(|bhit[b]),
        .cap_extra(many(bhit[b])),
        .cap_bits(ctx_bits[lowest(bhit[b])]),
        .cap_detail(cap_det[b]),
        .ack_en(ctx_ack_en[b]),
        .ack_bits(ctx_ack_data[CTX_BITS-1:0]),
        .ack_multi(ctx_ack_data[CS_MULTI]),
        .ss_set(|bstall[b]),
        .ss_clr(stall_resume[b]),
        .fault_bits(context_fault_status[b][CTX_BITS-1:0]),
        .multi(context_fault_status[b][CS_MULTI]),
        .ss(context_fault_status[b][CS_SS]),
        .detail({context_fault_syndrome[b], context_fault_address[b]})
      );

      // The abort mark holds until any acknowledge write to the bank clears
      // it; a new abort in that same cycle keeps it set.
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          s2_aborted_r[b] <= RST_BIT;
          xlate_op_terminated[b] <= RST_BIT;
        end else begin
          s2_aborted_r[b] <= (|bterm[b]) |
                             (s2_aborted_r[b] & ~ctx_ack_en[b]);
          // Each bank keeps its own operation result, independent of the
          // client record held in the same bank.
          if (op_done[b]) begin
            xlate_op_terminated[b] <= op_s2_fault[b];
          end
        end
      end

      a_ctx_multi: assert property (pend && (|bhit[b]) |=>
        context_fault_status[b][CS_MULTI])
        else $error("second context fault did not set multiple");
      a_first_kept: assert property (pend && (|bhit[b]) |=>
        $stable(context_fault_address[b]) &&
        $stable(context_fault_syndrome[b]))
        else $error("first fault detail overwritten");
      a_cap_detail: assert property (!pend && (|bhit[b]) |=>
        {context_fault_syndrome[b], context_fault_address[b]} ==
        $past(cap_det[b]))
        else $error("captured context detail wrong");
      a_ack_clear: assert property (ctx_ack_en[b] && ctx_ack_data[CS_TF] &&
        !(|bhit[b]) |=> !context_fault_status[b][CS_TF])
        else $error("write one did not clear fault bit");
      a_op_term: assert property (op_done[b] && op_s2_fault[b] |=>
        xlate_op_terminated[b] ##1 (xlate_op_terminated[b] ||
        $past(op_done[b])))
        else $error("operation terminated result missing");
    end
  endgenerate

  // Global record.
  logic [NP-1:0] s2_rec;
  logic gpend;

  assign s2_rec = rec_ctx & is_s2;
  assign gpend = |global_fault_status;

  iofr_record #(
    .SW(GL_BITS),
    .DW(ATTR_W)
  ) u_glb (
    .clk(clk),
    .resetn(resetn),
    .cap_valid(|rec_glb),
    .cap_extra(many(rec_glb)),
    .cap_bits(glb_bits[lowest(rec_glb)]),
    .cap_detail(raw_attr[lowest(rec_glb)]),
    .ack_en(gl_ack_en),
    .ack_bits(gl_ack_data[GL_BITS-1:0]),
    .ack_multi(gl_ack_data[GS_MULTI]),
    .ss_set(1'b0),
    .ss_clr(1'b0),
    .fault_bits(global_fault_status[GL_BITS-1:0]),
    .multi(global_fault_status[GS_MULTI]),
    .ss(),
    .detail(global_fault_syndrome0[ATTR_W-1:0])
  );

  assign global_fault_syndrome0[GSYN_NESTED] = nested_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nested_r <= RST_BIT;
      global_xlate_fault <= RST_BIT;
    end else begin
      if (|s2_rec) begin
        nested_r <= in_nested[lowest(s2_rec)];
      end
      // Own flag, so a global operation never touches the client records.
      global_xlate_fault <= (gop_done & gop_fault) |
                            (global_xlate_fault & ~gop_ack);
    end
  end

  a_glb_multi: assert property (gpend && (|rec_glb) |=>
    global_fault_status[GS_MULTI])
    else $error("second global fault did not set multiple");
  a_glb_attr: assert property (!gpend && (|rec_glb) |=>
    global_fault_syndrome0[ATTR_W-1:0] ==
    $past(raw_attr[lowest(rec_glb)]))
    else $error("global syndrome attributes wrong");
  a_nested_flag: assert property ((|s2_rec) |=>
    nested_r == $past(in_nested[lowest(s2_rec)]))
    else $error("nested flag not updated");

endmodule

// *** rtl/iofr_pkg.sv ***
package iofr_pkg;

  // Fault kinds presented with each translated client transaction outcome.
  typedef enum logic [3:0] {
    K_NONE,
    K_S1,
    K_S2_TRANS,
    K_S2_PERM,
    K_EXT,
    K_INV_CTX,
    K_UNIMPL_CB,
    K_UNIMPL_IRPT,
    K_GLB_OTHER
  } iofr_kind_e;

  // Context bank fault status layout.
  localparam int CS_TF = 0;
  localparam int CS_PF = 1;
  localparam int CS_EF = 2;
  localparam int CS_MULTI = 3;
  localparam int CS_SS = 4;
  localparam int CTX_BITS = 3;
  localparam int CS_W = 5;

  // Global fault status layout.
  localparam int GS_ICF = 0;
  localparam int GS_UCBF = 1;
  localparam int GS_UCIF = 2;
  localparam int GS_OTHER = 3;
  localparam int GS_MULTI = 4;
  localparam int GL_BITS = 4;
  localparam int GS_W = 5;

  // Syndrome layout, shared by context and global syndrome.
  localparam int SYN_NS = 0;
  localparam int SYN_PNU = 1;
  localparam int SYN_IND = 2;
  localparam int SYN_S1WALK = 3;
  localparam int GSYN_NESTED = 3;
  localparam int ATTR_W = 3;
  localparam int SYN_W = 4;

  // Override configuration encoding.
  localparam logic [1:0] OVR_KEEP = 2'h0;
  localparam logic [1:0] OVR_ZERO = 2'h2;
  localparam logic [1:0] OVR_ONE = 2'h3;

  // Reset values.
  localparam logic RST_BIT = 1'h0;

endpackage

// *** rtl/iofr_record.sv ***
module iofr_record
  import iofr_pkg::*;
#(
  parameter int SW = 3,
  parameter int DW = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fault capture
  input wire logic cap_valid,
  input wire logic cap_extra,
  input wire logic [SW-1:0] cap_bits,
  input wire logic [DW-1:0] cap_detail,
  // Software acknowledge, write one to clear
  input wire logic ack_en,
  input wire logic [SW-1:0] ack_bits,
  input wire logic ack_multi,
  // Stall status
  input wire logic ss_set,
  input wire logic ss_clr,
  // Record
  output logic [SW-1:0] fault_bits,
  output logic multi,
  output logic ss,
  output logic [DW-1:0] detail
);

  logic pending;
  logic take_first;
  logic [SW-1:0] ack_mask;
  logic [SW-1:0] bits_nxt;
  logic multi_nxt;

  // The stall bit does not count as a pending fault; it is not acknowledged
  // by a write but released by the resume of the held transaction.
  assign pending = (|fault_bits) | multi;
  assign take_first = cap_valid & ~pending;
  assign ack_mask = ack_en ? ack_bits : {SW{1'b0}};
  assign bits_nxt = take_first ? cap_bits : (fault_bits & ~ack_mask);
  // A new fault in the cycle of an acknowledge still marks the multiple flag.
  assign multi_nxt = (cap_valid & (pending | cap_extra)) |
                     (multi & ~(ack_en & ack_multi));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_bits <= {SW{RST_BIT}};
      multi <= RST_BIT;
      ss <= RST_BIT;
      detail <= {DW{RST_BIT}};
    end else begin
      fault_bits <= bits_nxt;
      multi <= multi_nxt;
      ss <= ss_set | (ss & ~ss_clr);
      if (take_first) begin
        detail <= cap_detail;
      end
    end
  end

endmodule
